// file: hw/alert_cause_pkg.sv
package alert_cause_pkg;

  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0]  STATUS_IDX       = 8'h26;
  localparam logic [7:0]  ENABLE_IDX       = 8'h40;
  localparam logic [7:0]  LIVE_IDX         = 8'h41;
  localparam logic [7:0]  PENDING_IDX      = 8'h42;
  localparam logic [7:0]  CONV_COUNT_IDX   = 8'h43;

  // values after reset
  localparam logic [23:0] STATUS_RESET     = 24'h00_0000;
  localparam logic [23:0] ENABLE_RESET     = 24'h00_000C;
  localparam logic [23:0] PENDING_RESET    = 24'h00_0000;
  localparam logic [31:0] RDATA_RESET      = 32'h0000_0000;

  // field positions inside the 24-bit cause word
  localparam int          OVER_CURRENT_LSB  = 20;
  localparam int          UNDER_CURRENT_LSB = 16;
  localparam int          OVER_VOLTAGE_LSB  = 12;
  localparam int          UNDER_VOLTAGE_LSB = 8;
  localparam int          OVER_POWER_LSB    = 4;
  localparam int          ACC_FULL_BIT      = 3;
  localparam int          COUNT_FULL_BIT    = 2;

  // bits 1..0 have no flip-flop behind them
  localparam logic [23:0] IMPL_MASK        = 24'hFF_FFFC;

  // bus answer timing: setup cycle plus one access cycle, no wait states
  localparam int          APB_WAIT_CYCLES  = 0;

  // one bit per channel for each limit, channel 1 in the most significant position; one bit each for the two accumulation flags
  typedef struct packed {
    logic [3:0] over_current_flag;
    logic [3:0] under_current_flag;
    logic [3:0] over_voltage_flag;
    logic [3:0] under_voltage_flag;
    logic [3:0] over_power_flag;
    logic       accumulator_full_flag;
    logic       sample_counter_full_flag;
    logic [1:0] unused;
  } cause_s;

  // limit comparison results from the conversion logic, same clock
  typedef struct packed {
    logic [3:0] over_current;
    logic [3:0] under_current;
    logic [3:0] over_voltage;
    logic [3:0] under_voltage;
    logic [3:0] over_power;
    logic [3:0] accumulator_full;
    logic       sample_counter_full;
  } limit_trip_s;

  typedef enum logic {APB_IDLE, APB_ACCESS} apb_phase_e;

  // byte address of a register index
  function automatic logic [9:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

endpackage

// file: hw/alert_cause_status_register.sv
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

// Operation
// R1 - bits 23 to 20 hold one overcurrent-tripped flag for channels 1 to 4, a one meaning tripped.
// R2 - bits 19 to 16 hold one undercurrent-tripped flag for channels 1 to 4, a one meaning tripped.
// R3 - bits 15 to 12 hold one overvoltage-tripped flag for channels 1 to 4, a one meaning tripped.
// R4 - bits 11 to 8 hold the undervoltage-tripped flags for channels 1 to 4 in channel order.
// R5 - bits 7 to 4 hold the overpower-tripped flags for channels 1 to 4 in channel order.
// R6 - bit 3 holds the accumulator full flag and bit 2 the sample counter full flag, both cleared by a read and a later finished conversion.
// R7 - bits 1 and 0 of the status word always read as zero.
// R8 - a flag clears once the word has been read and a later conversion cycle has finished.
// R9 - a flag whose cause is still present when the conversion cycle finishes stays set despite the read.
// R10 - the readable status follows the flags directly, with no snapshot command in between.
// R11 - the limit alerts are disabled after reset until software sets their enable bits.
// R12 - software reads the status word after an alert to learn which cause raised it.
// R13 - the accumulator full flag sets when any channel accumulator overflows or passes its limit.
// R14 - the sample counter full flag sets when the sample counter overflows or passes its limit.
// R15 - a read clears only the flags that it returned as set, so a cause arising meanwhile survives.
module alert_cause_status_register
  import alert_cause_pkg::*;
#(
  parameter int ADDR_W     = 12,
  parameter int NUM_CH     = 4,
  parameter int CONV_CNT_W = 16
) (
  input  wire logic              mclk_in,
  input  wire logic              resetn_in,
  // apb slave
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  // conversion logic side
  input  wire logic              conv_done_in,
  input  wire limit_trip_s       trip_in,
  // flag view and combined alert
  output cause_s                 status_out,
  output logic                   alert_out
);

  // elaboration checks: the bit layout is built for four channels only
  if (NUM_CH != 4) begin : g_bad_ch
    $error("alert_cause_status_register: NUM_CH must be 4");
  end
  if (ADDR_W < 10) begin : g_bad_addr
    $error("alert_cause_status_register: ADDR_W must be at least 10");
  end
  if (CONV_CNT_W < 1 || CONV_CNT_W > 32) begin : g_bad_cnt
    $error("alert_cause_status_register: CONV_CNT_W must be 1 to 32");
  end

  // flip-flops
  apb_phase_e            phase_r;
  apb_phase_e            phase_nxt;
  logic [23:0]           status_r;
  logic [23:0]           status_nxt;
  logic [23:0]           enable_r;
  logic [23:0]           enable_nxt;
  logic [23:0]           pending_r;
  logic [23:0]           pending_nxt;
  logic [CONV_CNT_W-1:0] conv_count_r;
  logic [CONV_CNT_W-1:0] conv_count_nxt;
  logic [31:0]           prdata_r;
  logic [31:0]           prdata_nxt;
  logic                  pready_r;
  logic                  pready_nxt;
  logic                  pslverr_r;
  logic                  pslverr_nxt;
  logic                  alert_r;
  logic                  alert_nxt;

  // decode wires
  logic [ADDR_W-1:0]     addr_status;
  logic [ADDR_W-1:0]     addr_enable;
  logic [ADDR_W-1:0]     addr_live;
  logic [ADDR_W-1:0]     addr_pending;
  logic [ADDR_W-1:0]     addr_conv;
  logic                  hit_status;
  logic                  hit_enable;
  logic                  hit_live;
  logic                  hit_pending;
  logic                  hit_conv;
  logic                  hit_any;
  logic                  setup_w;
  logic                  done_w;
  logic                  wr_enable_w;
  logic                  rd_status_w;
  logic [31:0]           rd_mux;

  // flag wires
  logic [23:0]           raw_cause;
  logic [23:0]           live_cause;
  logic [23:0]           read_clear;
  logic [23:0]           conv_clear;
  logic [23:0]           conv_keep;
  logic [31:0]           status_word;

  // named flag views, channel 1 first in each group
  // overcurrent
  logic                  chan1_over_current_flag;
  logic                  chan2_over_current_flag;
  logic                  chan3_over_current_flag;
  logic                  chan4_over_current_flag;
  // undercurrent
  logic                  chan1_under_current_flag;
  logic                  chan2_under_current_flag;
  logic                  chan3_under_current_flag;
  logic                  chan4_under_current_flag;
  // overvoltage
  logic                  chan1_over_voltage_flag;
  logic                  chan2_over_voltage_flag;
  logic                  chan3_over_voltage_flag;
  logic                  chan4_over_voltage_flag;
  // undervoltage
  logic                  chan1_under_voltage_flag;
  logic                  chan2_under_voltage_flag;
  logic                  chan3_under_voltage_flag;
  logic                  chan4_under_voltage_flag;
  // overpower
  logic                  chan1_over_power_flag;
  logic                  chan2_over_power_flag;
  logic                  chan3_over_power_flag;
  logic                  chan4_over_power_flag;
  // accumulation
  logic                  accumulator_full_flag;
  logic                  sample_counter_full_flag;

  // register byte addresses widened to the bus address
  assign addr_status  = ADDR_W'(byte_addr(STATUS_IDX));
  assign addr_enable  = ADDR_W'(byte_addr(ENABLE_IDX));
  assign addr_live    = ADDR_W'(byte_addr(LIVE_IDX));
  assign addr_pending = ADDR_W'(byte_addr(PENDING_IDX));
  assign addr_conv    = ADDR_W'(byte_addr(CONV_COUNT_IDX));

  // address hits; a misaligned address matches nothing and so errors
  assign hit_status  = (paddr_in == addr_status);
  assign hit_enable  = (paddr_in == addr_enable);
  assign hit_live    = (paddr_in == addr_live);
  assign hit_pending = (paddr_in == addr_pending);
  assign hit_conv    = (paddr_in == addr_conv);
  assign hit_any     = hit_status | hit_enable | hit_live | hit_pending | hit_conv;

  // setup is taken once per transfer, completion when the access meets ready
  assign setup_w     = psel_in & ~penable_in & (phase_r == APB_IDLE);
  assign done_w      = psel_in & penable_in & pready_r & (phase_r == APB_ACCESS);
  assign wr_enable_w = done_w & pwrite_in & hit_enable;
  assign rd_status_w = done_w & ~pwrite_in & hit_status;

  // raw cause word in status bit order; one process, so the word has one driver
  always_comb begin
    raw_cause[OVER_CURRENT_LSB +: 4]  = trip_in.over_current;         // R1
    raw_cause[UNDER_CURRENT_LSB +: 4] = trip_in.under_current;        // R2
    raw_cause[OVER_VOLTAGE_LSB +: 4]  = trip_in.over_voltage;         // R3
    raw_cause[UNDER_VOLTAGE_LSB +: 4] = trip_in.under_voltage;        // R4
    raw_cause[OVER_POWER_LSB +: 4]    = trip_in.over_power;           // R5
    raw_cause[ACC_FULL_BIT]           = |trip_in.accumulator_full;    // R13
    raw_cause[COUNT_FULL_BIT]         = trip_in.sample_counter_full;  // R14
    raw_cause[1:0]                    = 2'b00;                        // R7
  end

  // only enabled causes may raise a flag; limits start disabled
  assign live_cause = raw_cause & enable_r & IMPL_MASK;  // R11

  // a read clears exactly what it returned, taken from the latched read data
  assign read_clear = rd_status_w ? prdata_r[23:0] : 24'h00_0000;  // R15

  // clearing happens only at the end of a conversion after the read
  assign conv_clear = conv_done_in ? pending_r : 24'h00_0000;  // R8

  // new cause wins over a clear in the same cycle, so no event is lost
  assign status_nxt = ((status_r & ~conv_clear) | live_cause) & IMPL_MASK;  // R9 R6

  // a finished conversion retires the clear mask, except where the cause is
  // still there: that flag stays set and clears at the first conversion that
  // finds its cause gone; a read during the finishing conversion waits
  assign conv_keep   = pending_r & live_cause;  // R9
  assign pending_nxt = conv_done_in ? (read_clear | conv_keep) : (pending_r | read_clear);  // R8

  // software owns the enables; reserved bits stay zero
  assign enable_nxt = wr_enable_w ? (pwdata_in[23:0] & IMPL_MASK) : enable_r;  // R11

  // diagnostic count of finished conversions, wraps silently
  assign conv_count_nxt = conv_done_in ? conv_count_r + CONV_CNT_W'(1) : conv_count_r;

  // combined alert follows the flags with no snapshot step
  assign alert_nxt = |status_nxt;  // R10

  // named flags picked out of the status register
  // overcurrent, bits 23 down to 20
  assign chan1_over_current_flag  = status_r[OVER_CURRENT_LSB + 3];   // R1
  assign chan2_over_current_flag  = status_r[OVER_CURRENT_LSB + 2];   // R1
  assign chan3_over_current_flag  = status_r[OVER_CURRENT_LSB + 1];   // R1
  assign chan4_over_current_flag  = status_r[OVER_CURRENT_LSB];       // R1
  // undercurrent, bits 19 down to 16
  assign chan1_under_current_flag = status_r[UNDER_CURRENT_LSB + 3];  // R2
  assign chan2_under_current_flag = status_r[UNDER_CURRENT_LSB + 2];  // R2
  assign chan3_under_current_flag = status_r[UNDER_CURRENT_LSB + 1];  // R2
  assign chan4_under_current_flag = status_r[UNDER_CURRENT_LSB];      // R2
  // overvoltage, bits 15 down to 12
  assign chan1_over_voltage_flag  = status_r[OVER_VOLTAGE_LSB + 3];   // R3
  assign chan2_over_voltage_flag  = status_r[OVER_VOLTAGE_LSB + 2];   // R3
  assign chan3_over_voltage_flag  = status_r[OVER_VOLTAGE_LSB + 1];   // R3
  assign chan4_over_voltage_flag  = status_r[OVER_VOLTAGE_LSB];       // R3
  // undervoltage, bits 11 down to 8
  assign chan1_under_voltage_flag = status_r[UNDER_VOLTAGE_LSB + 3];  // R4
  assign chan2_under_voltage_flag = status_r[UNDER_VOLTAGE_LSB + 2];  // R4
  assign chan3_under_voltage_flag = status_r[UNDER_VOLTAGE_LSB + 1];  // R4
  assign chan4_under_voltage_flag = status_r[UNDER_VOLTAGE_LSB];      // R4
  // overpower, bits 7 down to 4
  assign chan1_over_power_flag    = status_r[OVER_POWER_LSB + 3];     // R5
  assign chan2_over_power_flag    = status_r[OVER_POWER_LSB + 2];     // R5
  assign chan3_over_power_flag    = status_r[OVER_POWER_LSB + 1];     // R5
  assign chan4_over_power_flag    = status_r[OVER_POWER_LSB];         // R5
  // accumulation, bits 3 and 2
  assign accumulator_full_flag    = status_r[ACC_FULL_BIT];           // R6
  assign sample_counter_full_flag = status_r[COUNT_FULL_BIT];         // R6

  // word as the bus returns it; the top byte and bits 1..0 have no storage,
  // so they are built as zeros here rather than trusted from the register
  assign status_word = {
    8'h00,
    // current limits
    chan1_over_current_flag,
    chan2_over_current_flag,
    chan3_over_current_flag,
    chan4_over_current_flag,
    chan1_under_current_flag,
    chan2_under_current_flag,
    chan3_under_current_flag,
    chan4_under_current_flag,
    // voltage limits
    chan1_over_voltage_flag,
    chan2_over_voltage_flag,
    chan3_over_voltage_flag,
    chan4_over_voltage_flag,
    chan1_under_voltage_flag,
    chan2_under_voltage_flag,
    chan3_under_voltage_flag,
    chan4_under_voltage_flag,
    // power and accumulation
    chan1_over_power_flag,
    chan2_over_power_flag,
    chan3_over_power_flag,
    chan4_over_power_flag,
    accumulator_full_flag,
    sample_counter_full_flag,
    2'b00  // R7
  };

  // read data selection
  always_comb begin
    if (hit_status) begin
      rd_mux = status_word;  // R10 R7
    end else if (hit_enable) begin
      rd_mux = {8'h00, enable_r};
    end else if (hit_live) begin
      rd_mux = {8'h00, raw_cause};
    end else if (hit_pending) begin
      rd_mux = {8'h00, pending_r};
    end else if (hit_conv) begin
      rd_mux = 32'(conv_count_r);
    end else begin
      rd_mux = RDATA_RESET;
    end
  end

  // bus phase machine; read data is latched at setup so that the
  // clear mask and the returned value are the very same bits
  always_comb begin
    phase_nxt   = phase_r;
    pready_nxt  = pready_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    case (phase_r)
      APB_IDLE: begin
        if (setup_w) begin
          phase_nxt   = APB_ACCESS;
          pready_nxt  = 1'b1;
          prdata_nxt  = pwrite_in ? RDATA_RESET : rd_mux;
          pslverr_nxt = ~hit_any;
        end
      end
      APB_ACCESS: begin
        if (done_w || !psel_in) begin
          phase_nxt   = APB_IDLE;
          pready_nxt  = 1'b0;
          pslverr_nxt = 1'b0;
        end
      end
      default: begin
        phase_nxt   = APB_IDLE;
        pready_nxt  = 1'b0;
        pslverr_nxt = 1'b0;
      end
    endcase
  end

  // bus registers
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase_r   <= APB_IDLE;
      pready_r  <= 1'b0;
      prdata_r  <= RDATA_RESET;
      pslverr_r <= 1'b0;
    end else begin
      phase_r   <= phase_nxt;
      pready_r  <= pready_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // flag registers; all read zero at power-on
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_r  <= STATUS_RESET;
      pending_r <= PENDING_RESET;
      alert_r   <= 1'b0;
    end else begin
      status_r  <= status_nxt;   // R1 R2 R3 R4 R5 R6
      pending_r <= pending_nxt;
      alert_r   <= alert_nxt;
    end
  end

  // configuration and diagnostics
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      enable_r     <= ENABLE_RESET;  // R11
      conv_count_r <= '0;
    end else begin
      enable_r     <= enable_nxt;
      conv_count_r <= conv_count_nxt;
    end
  end

  // outputs straight from flip-flops
  assign prdata_out  = prdata_r;
  assign pready_out  = pready_r;
  assign pslverr_out = pslverr_r;
  assign status_out  = cause_s'(status_r);
  assign alert_out   = alert_r;

endmodule // alert_cause_status_register

// file: dv/alert_cause_props.sv
`timescale 1ns/1ps
module alert_cause_props
  import alert_cause_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              mclk_in,
  input  wire logic              resetn_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       prdata_out,
  input  wire logic              pready_out,
  input  wire logic              pslverr_out,
  input  wire logic              conv_done_in,
  input  wire limit_trip_s       trip_in,
  input  wire cause_s            status_out,
  input  wire logic              alert_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // bit layout and combined alert
  low_bits_zero_a: assert property (status_out[1:0] == 2'b00)
    else $error("status low bits set");
  alert_follows_a: assert property (alert_out == (status_out != 24'h00_0000))
    else $error("alert does not follow flags");
  status_read_a: assert property (pready_out && !pwrite_in && paddr_in == {STATUS_IDX, 2'b00}
    |-> prdata_out[31:24] == 8'h00 && prdata_out[1:0] == 2'b00) else $error("status read spare bits");
  // zero wait states: ready only in the first access cycle
  ready_next_a: assert property (psel_in && !penable_in |=> pready_out ##1 !pready_out)
    else $error("ready timing");
  // flag set and clear causes; acc causes stay enabled in every scenario
  acc_set_a: assert property (|trip_in.accumulator_full |=> status_out.accumulator_full_flag)
    else $error("accumulator flag not set");
  count_set_a: assert property ($rose(status_out.sample_counter_full_flag) |-> $past(trip_in.sample_counter_full))
    else $error("counter flag without cause");
  hold_cause_a: assert property (status_out.sample_counter_full_flag && trip_in.sample_counter_full
    |=> status_out.sample_counter_full_flag) else $error("flag dropped while cause present");
  clear_on_conv_a: assert property (($past(status_out) & ~status_out) != 24'h00_0000 |-> $past(conv_done_in))
    else $error("flag cleared without conversion end");
  read_done_c: cover property (pready_out && !pwrite_in);
  flag_clear_c: cover property (conv_done_in && status_out != 24'h00_0000);
  bus_error_c: cover property (pready_out && pslverr_out);
endmodule // alert_cause_props

bind alert_cause_status_register alert_cause_props #(.ADDR_W(ADDR_W)) props (.mclk_in, .resetn_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .prdata_out, .pready_out, .pslverr_out, .conv_done_in, .trip_in,
  .status_out, .alert_out);

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench
  import alert_cause_pkg::*;
;
  localparam logic [11:0] ST = 12'h098;
  localparam logic [11:0] EN = 12'h100;
  localparam logic [11:0] LV = 12'h104;
  localparam logic [11:0] PD = 12'h108;
  localparam logic [11:0] CN = 12'h10C;
  logic        mclk_in = 0, resetn_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, conv_done_in = 0;
  logic [11:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0, prdata_out, rd;
  logic        pready_out, pslverr_out, alert_out, er;
  limit_trip_s trip_in = '0;
  cause_s      status_out;
  int          fails = 0, n_checks = 0;

  always #2 mclk_in = ~mclk_in;

  alert_cause_status_register dut (.mclk_in, .resetn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .conv_done_in, .trip_in, .status_out, .alert_out);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one transfer; waits for ready, only the watchdog ends a wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge mclk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge mclk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic conv();
    @(posedge mclk_in);
    conv_done_in <= 1'b1;
    @(posedge mclk_in);
    conv_done_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic trip(input limit_trip_s t);
    @(posedge mclk_in);
    trip_in <= t;
    @(posedge mclk_in);
    trip_in <= '0;
  endtask
  task automatic do_reset();
    resetn_in <= 1'b0;
    repeat (8) @(posedge mclk_in);
    resetn_in <= 1'b1;
  endtask
  // limit causes start disabled, so a trip leaves no mark
  task automatic t_reset();
    limit_trip_s t;
    t = '0;
    t.over_current = 4'h8;
    trip(t);
    @(posedge mclk_in);
    chk({8'h00, status_out}, 32'h0000_0000);
    apb(1'b0, EN, '0);
    chk(rd, 32'h0000_000C);
    apb(1'b0, ST, '0);
    chk(rd, 32'h0000_0000);
  endtask
  // walk every cause bit through set, read and clear
  task automatic t_fields();
    logic [23:0] e;
    apb(1'b1, EN, 32'h00FF_FFFC);
    for (int i = 0; i < 25; i++) begin
      e = (i >= 5) ? 24'h00_0001 << (i - 1) : (i > 0) ? 24'h00_0008 : 24'h00_0004;
      trip(limit_trip_s'(25'h000_0001 << i));
      apb(1'b0, ST, '0);
      chk(rd, {8'h00, e});
      chk(alert_out, 1'b1);
      conv();
      chk({8'h00, status_out}, 32'h0000_0000);
      chk(alert_out, 1'b0);
    end
  endtask
  task automatic t_persist();
    limit_trip_s t;
    t = '0;
    t.sample_counter_full = 1'b1;
    @(posedge mclk_in);
    trip_in <= t;
    conv();
    chk({8'h00, status_out}, 32'h0000_0004);
    apb(1'b0, ST, '0);
    apb(1'b0, PD, '0);
    chk(rd, 32'h0000_0004);
    apb(1'b0, LV, '0);
    chk(rd, 32'h0000_0004);
    conv();
    chk({8'h00, status_out}, 32'h0000_0004);
    apb(1'b0, PD, '0);
    chk(rd, 32'h0000_0004);
    trip_in <= '0;
    conv();
    chk({8'h00, status_out}, 32'h0000_0000);
    trip(t);
    apb(1'b0, ST, '0);
    t = '0;
    t.over_power = 4'h1;
    trip(t);
    conv();
    chk({8'h00, status_out}, 32'h0000_0010);
  endtask
  // writes leave the word alone; unmapped place errors; reset in mid-run
  task automatic t_bus();
    apb(1'b1, ST, 32'hFFFF_FFFF);
    chk({8'h00, status_out}, 32'h0000_0010);
    apb(1'b0, 12'h3F0, '0);
    chk(rd, 32'h0000_0000);
    chk(er, 1'b1);
    apb(1'b0, 12'h099, '0);
    chk(rd, 32'h0000_0000);
    chk(er, 1'b1);
    do_reset();
    @(posedge mclk_in);
    chk({8'h00, status_out}, 32'h0000_0000);
    apb(1'b0, EN, '0);
    chk(rd, 32'h0000_000C);
    apb(1'b0, CN, '0);
    chk(rd, 32'h0000_0000);
    conv();
    apb(1'b0, CN, '0);
    chk(rd, 32'h0000_0001);
  endtask
  task automatic results();
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    do_reset();
    t_reset();
    t_fields();
    t_persist();
    t_bus();
    results();
  end
  // watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk_in);
    fails++;
    results();
  end
endmodule // testbench
